// File: rtl/ahcd_pkg.sv
// Behaviour
// RULE1: Count type 1 takes the first index after sensor plus travel as home.
// RULE2: Count types are refused when the sensor comes from the amplifier.
// RULE3: Count type 1 without index pass stops and raises error 120.
// RULE4: With waiver set, count type 1 completes without index pass.
// RULE5: Starting with sensor asserted, first back off until sensor releases.
// RULE6: Travel shorter than deceleration distance raises error 209 and stops.
// RULE7: Homing completes only after in-position asserts.
// RULE8: Count type 2 takes the position after travel as home.
// RULE9: Count type 2 records the command position as home.
// RULE10: Count type 3 with index passed behaves as count type 1.
// RULE11: Count type 3 without index reverses one turn, then retries.
// RULE12: Count type 3 with waiver treats zero pass as set.
// RULE13: Data-set type 1 ignores sensor and latches command position.
// RULE14: Data-set types raise no-zero-pass error unless waiver is set.
// RULE15: Data-set type 1 without absolute system overwrites current position.
// RULE16: Data-set requests supply only direction and home address.
// RULE17: Data-set type 2 latches the real measured position.
// RULE18: Operators should prefer count type 3 when home is very close.
// RULE19: Zero-pass flag sets on first index and holds until power off.
package ahcd_pkg;

  localparam int POS_W = 32;

  typedef enum logic [2:0] {
    AHCD_COUNT1 = 3'h0,
    AHCD_COUNT2 = 3'h1,
    AHCD_COUNT3 = 3'h2,
    AHCD_DSET1 = 3'h3,
    AHCD_DSET2 = 3'h4
  } ahcd_method_t;

  // APB register offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TRAVEL = 8'h04;
  localparam logic [7:0] REG_DECEL = 8'h08;
  localparam logic [7:0] REG_HOME_ADDR = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam logic [7:0] REG_HOME_POS = 8'h1C;
  localparam logic [7:0] REG_ERR_CODE = 8'h20;
  localparam logic [7:0] REG_REV = 8'h24;

  // Control register fields.
  localparam int CTRL_START = 0;
  localparam int CTRL_DIR = 1;
  localparam int CTRL_AMP_SENSOR = 2;
  localparam int CTRL_WAIVER = 3;
  localparam int CTRL_ABS = 4;
  localparam int CTRL_METHOD_LSB = 8;
  localparam int CTRL_ABORT = 16;

  // Interrupt status bits.
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_ZPASS = 2;
  localparam int IRQ_W = 3;

  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_ZCT = 16'h0078;
  localparam logic [15:0] ERR_OVERRUN = 16'h00D1;
  localparam logic [15:0] ERR_NO_ZERO = 16'h0079;
  localparam logic [15:0] ERR_AMP_SENSOR = 16'h008E;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [POS_W-1:0] REV_RESET = 32'h0000_1000;

  typedef struct packed {
    logic run;
    logic dir;
    logic creep;
  } ahcd_motion_t;

  typedef struct packed {
    logic [POS_W-1:0] cmd_pos;
    logic [POS_W-1:0] real_pos;
  } ahcd_pos_t;

endpackage

// File: rtl/ahcd_homing.sv
`timescale 1ns/10ps
module ahcd_homing
  import ahcd_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Axis inputs
  input wire logic i_prox_sensor,
  input wire logic i_encoder_index,
  input wire logic i_in_position_flag,
  input wire ahcd_pos_t i_pos,
  // Motion command and result
  output ahcd_motion_t o_motion,
  output logic o_pos_load,
  output logic [POS_W-1:0] o_pos_value,
  output logic o_zero_pass_flag,
  output logic o_irq
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_BACKOFF, ST_SEEK, ST_TRAVEL, ST_INDEX, ST_REVERSE, ST_SETTLE
  } ahcd_state_t;

  ahcd_state_t state_q;
  logic [31:0] ctrl_q, ctrl_cur;
  logic [POS_W-1:0] travel_q, decel_q, home_addr_q, rev_q, home_pos_q, start_q;
  logic [15:0] err_q;
  logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set;
  logic zero_pass_q, index_in_travel_q, retried_q, busy;
  logic pos_load_q;
  logic [POS_W-1:0] pos_value_q;
  ahcd_motion_t motion_q;

  logic wr, rd_access, start_req, abort_req, waiver, zp_eff;
  ahcd_method_t method;
  logic [POS_W-1:0] moved, delta;

  assign wr = i_psel && i_penable && i_pwrite;
  assign rd_access = i_psel && i_penable && !i_pwrite;
  assign o_pready = 1'b1;
  assign start_req = wr && i_paddr == REG_CTRL && i_pwdata[CTRL_START] && !busy;
  assign abort_req = wr && i_paddr == REG_CTRL && i_pwdata[CTRL_ABORT];
  // A start written together with its settings must use the new settings.
  assign ctrl_cur = (wr && i_paddr == REG_CTRL) ? {i_pwdata[31:1], 1'b0} : ctrl_q;
  assign method = ahcd_method_t'(ctrl_cur[CTRL_METHOD_LSB +: 3]);
  assign waiver = ctrl_cur[CTRL_WAIVER];
  // Waiver makes the flag count as set for as long as the waiver bit is set.
  assign zp_eff = zero_pass_q || waiver; // [RULE12]
  assign busy = state_q != ST_IDLE;
  // Distance is taken modulo the position width, so travel through zero is measured correctly.
  assign delta = i_pos.cmd_pos - start_q;
  assign moved = delta[POS_W-1] ? -delta : delta;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      ctrl_q <= CTRL_RESET;
      travel_q <= '0;
      decel_q <= '0;
      home_addr_q <= '0;
      rev_q <= REV_RESET;
      irq_mask_q <= '0;
    end
    else if (i_ce && wr)
    begin
      case (i_paddr)
        REG_CTRL: ctrl_q <= {i_pwdata[31:1], 1'b0};
        REG_TRAVEL: travel_q <= i_pwdata;
        REG_DECEL: decel_q <= i_pwdata;
        REG_HOME_ADDR: home_addr_q <= i_pwdata;
        REG_IRQ_MASK: irq_mask_q <= i_pwdata[IRQ_W-1:0];
        REG_REV: rev_q <= i_pwdata;
        default: ;
      endcase
    end
  end

  // Sticky until power loss; only reset clears it.
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      zero_pass_q <= 1'b0;
    else if (i_ce && i_encoder_index)
      zero_pass_q <= 1'b1; // [RULE19]
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      irq_stat_q <= '0;
    else if (i_ce)
    begin
      if (wr && i_paddr == REG_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~i_pwdata[IRQ_W-1:0]) | irq_set;
      else
        irq_stat_q <= irq_stat_q | irq_set;
    end
  end
  assign o_irq = |(irq_stat_q & ~irq_mask_q);

  always_comb
  begin
    o_prdata = '0;
    o_pslverr = 1'b0;
    if (rd_access)
    begin
      case (i_paddr)
        REG_CTRL: o_prdata = ctrl_q;
        REG_TRAVEL: o_prdata = travel_q;
        REG_DECEL: o_prdata = decel_q;
        REG_HOME_ADDR: o_prdata = home_addr_q;
        REG_STATUS: o_prdata = {28'h0, motion_q.run, zero_pass_q, i_in_position_flag, busy};
        REG_IRQ_STAT: o_prdata = {29'h0, irq_stat_q};
        REG_IRQ_MASK: o_prdata = {29'h0, irq_mask_q};
        REG_HOME_POS: o_prdata = home_pos_q;
        REG_ERR_CODE: o_prdata = {16'h0, err_q};
        REG_REV: o_prdata = rev_q;
        default: o_pslverr = 1'b1;
      endcase
    end
    else if (wr && i_paddr > REG_REV)
      o_pslverr = 1'b1;
  end

  // Homing sequencer.
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_q <= ST_IDLE;
      motion_q <= '0;
      err_q <= ERR_NONE;
      home_pos_q <= '0;
      start_q <= '0;
      index_in_travel_q <= 1'b0;
      retried_q <= 1'b0;
      pos_load_q <= 1'b0;
      pos_value_q <= '0;
      irq_set <= '0;
    end
    else if (i_ce)
    begin
      pos_load_q <= 1'b0;
      irq_set <= '0;
      irq_set[IRQ_ZPASS] <= i_encoder_index && !zero_pass_q;
      if (abort_req && busy)
      begin
        motion_q <= '0;
        state_q <= ST_IDLE;
      end
      else
      case (state_q)
        ST_IDLE:
        begin
          if (start_req)
          begin
            err_q <= ERR_NONE;
            retried_q <= 1'b0;
            index_in_travel_q <= 1'b0;
            if (method == AHCD_DSET1 || method == AHCD_DSET2)
            begin
              // Sensor, travel and deceleration settings are not used here.
              if (!zp_eff) // [RULE14]
              begin
                err_q <= ERR_NO_ZERO;
                irq_set[IRQ_ERR] <= 1'b1;
              end
              else
              begin
                // Command position, or real position for type 2.
                home_pos_q <= (method == AHCD_DSET1) ? i_pos.cmd_pos : i_pos.real_pos; // [RULE13] [RULE17]
                pos_load_q <= !ctrl_cur[CTRL_ABS]; // [RULE15]
                pos_value_q <= home_addr_q;
                state_q <= ST_SETTLE;
              end
            end
            else if (ctrl_cur[CTRL_AMP_SENSOR])
            begin
              err_q <= ERR_AMP_SENSOR; // [RULE2]
              irq_set[IRQ_ERR] <= 1'b1;
            end
            else if (travel_q < decel_q)
            begin
              err_q <= ERR_OVERRUN; // [RULE6]
              irq_set[IRQ_ERR] <= 1'b1;
            end
            else if (i_prox_sensor)
            begin
              motion_q <= '{run: 1'b1, dir: !ctrl_cur[CTRL_DIR], creep: 1'b1}; // [RULE5]
              state_q <= ST_BACKOFF;
            end
            else
            begin
              motion_q <= '{run: 1'b1, dir: ctrl_cur[CTRL_DIR], creep: 1'b0};
              state_q <= ST_SEEK;
            end
          end
        end
        ST_BACKOFF:
        begin
          if (!i_prox_sensor)
          begin
            motion_q <= '{run: 1'b1, dir: ctrl_q[CTRL_DIR], creep: 1'b0}; // [RULE5]
            state_q <= ST_SEEK;
          end
        end
        ST_SEEK:
        begin
          if (i_encoder_index)
            index_in_travel_q <= 1'b1;
          if (i_prox_sensor)
          begin
            start_q <= i_pos.cmd_pos;
            state_q <= ST_TRAVEL;
          end
        end
        ST_TRAVEL:
        begin
          if (i_encoder_index)
            index_in_travel_q <= 1'b1;
          if (moved >= decel_q)
            motion_q.creep <= 1'b1;
          if (moved >= travel_q)
          begin
            if (method == AHCD_COUNT2)
            begin
              motion_q <= '0;
              home_pos_q <= i_pos.cmd_pos; // [RULE8] [RULE9]
              state_q <= ST_SETTLE;
            end
            else if (index_in_travel_q || zp_eff) // [RULE4] [RULE10] [RULE12]
              state_q <= ST_INDEX; // [RULE1]
            else if (method == AHCD_COUNT3 && !retried_q)
            begin
              motion_q <= '{run: 1'b1, dir: !ctrl_q[CTRL_DIR], creep: 1'b1}; // [RULE11]
              start_q <= i_pos.cmd_pos;
              retried_q <= 1'b1;
              state_q <= ST_REVERSE;
            end
            else
            begin
              motion_q <= '0; // [RULE3]
              err_q <= ERR_ZCT;
              irq_set[IRQ_ERR] <= 1'b1;
              state_q <= ST_IDLE;
            end
          end
        end
        ST_REVERSE:
        begin
          if (i_encoder_index)
            index_in_travel_q <= 1'b1;
          if (moved >= rev_q && index_in_travel_q)
          begin
            motion_q <= '{run: 1'b1, dir: ctrl_q[CTRL_DIR], creep: 1'b1}; // [RULE11]
            state_q <= i_prox_sensor ? ST_BACKOFF : ST_SEEK;
            if (i_prox_sensor)
              motion_q.dir <= !ctrl_q[CTRL_DIR];
          end
        end
        ST_INDEX:
        begin
          if (i_encoder_index)
          begin
            motion_q <= '0;
            home_pos_q <= i_pos.real_pos; // [RULE1]
            state_q <= ST_SETTLE;
          end
        end
        ST_SETTLE:
        begin
          if (i_in_position_flag) // [RULE7]
          begin
            irq_set[IRQ_DONE] <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign o_motion = motion_q;
  assign o_pos_load = pos_load_q;
  assign o_pos_value = pos_value_q;
  assign o_zero_pass_flag = zero_pass_q;

endmodule

// File: tb/ahcd_servo_model.sv
`timescale 1ns/10ps
module ahcd_servo_model
  import ahcd_pkg::*;
#(
  parameter int REV = 64,
  parameter int DOG = 10
)
(
  // Motion in
  input wire logic i_clk,
  input wire ahcd_motion_t i_motion,
  input wire logic i_jog,
  input wire logic [POS_W-1:0] i_jog_pos,
  // Encoder and sensors out
  output ahcd_pos_t o_pos,
  output logic o_index,
  output logic o_prox,
  output logic o_inpos
);
  int p_q = 0;
  int last_q = 0;
  int settle_q = 0;
  always @(posedge i_clk)
  begin
    if (i_jog)
      p_q <= int'(i_jog_pos);
    else if (i_motion.run)
      p_q <= i_motion.dir ? p_q + 1 : p_q - 1;
    last_q <= i_jog ? int'(i_jog_pos) : p_q;
    settle_q <= i_motion.run ? 8 : (settle_q > 0 ? settle_q - 1 : 0);
  end
  // A jog never fires the index; the measured position is offset from the command.
  assign o_index = (p_q != last_q) && (p_q % REV == 0);
  assign o_prox = (p_q >= DOG) && (p_q < DOG + 20);
  assign o_inpos = (settle_q == 0);
  assign o_pos = '{cmd_pos: POS_W'(p_q), real_pos: POS_W'(p_q + 3)};
endmodule

// File: tb/ahcd_homing_chk.sv
`timescale 1ns/10ps
module ahcd_homing_chk
  import ahcd_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Control
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Register bus
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Axis
  input wire logic i_prox_sensor,
  input wire logic i_encoder_index,
  input wire logic i_in_position_flag,
  input wire ahcd_pos_t i_pos,
  input wire ahcd_motion_t o_motion,
  input wire logic o_pos_load,
  input wire logic [POS_W-1:0] o_pos_value,
  input wire logic o_zero_pass_flag,
  input wire logic o_irq
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  sequence s_acc;
    i_psel && i_penable;
  endsequence
  sequence s_idx;
    i_encoder_index && i_ce;
  endsequence
  property p_ready;
    s_acc |-> o_pready;
  endproperty
  property p_err_hi;
    s_acc ##0 (i_paddr > ADDR_W'(REG_REV)) |-> o_pslverr;
  endproperty
  property p_err_lo;
    s_acc ##0 (i_paddr <= ADDR_W'(REG_REV) && i_paddr[1:0] == 2'h0) |-> !o_pslverr;
  endproperty
  property p_err_idle;
    !(i_psel && i_penable) |-> !o_pslverr;
  endproperty
  property p_zp_set;
    s_idx |=> o_zero_pass_flag [*3];
  endproperty
  property p_zp_hold;
    o_zero_pass_flag |=> o_zero_pass_flag;
  endproperty
  property p_zp_read;
    s_acc ##0 (!i_pwrite && i_paddr == ADDR_W'(REG_STATUS)) |-> o_prdata[2] == o_zero_pass_flag;
  endproperty
  property p_zp_rise;
    !o_zero_pass_flag && !(i_encoder_index && i_ce) |=> !o_zero_pass_flag;
  endproperty
  property p_load;
    o_pos_load |=> !o_pos_load;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_err_hi: assert property (p_err_hi) else $error("no slave error");
  a_err_lo: assert property (p_err_lo) else $error("false slave error");
  a_err_idle: assert property (p_err_idle) else $error("slave error outside access");
  a_zp_set: assert property (p_zp_set) else $error("zero pass not set");
  a_zp_hold: assert property (p_zp_hold) else $error("zero pass lost");
  a_zp_read: assert property (p_zp_read) else $error("status zero pass wrong");
  a_zp_rise: assert property (p_zp_rise) else $error("zero pass set without index");
  a_load: assert property (p_load) else $error("load pulse too long");
endmodule
bind ahcd_homing ahcd_homing_chk #(.ADDR_W(ADDR_W)) ahcd_homing_chk_inst (.*);

// File: tb/test_axis_homing_count_dataset.sv
`timescale 1ns/10ps
module test_axis_homing_count_dataset;
  import ahcd_pkg::*;
  localparam int REV = 64;
  localparam int DOG = 10;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic manual_jog = 1'b0;
  logic ce = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] jpos = 32'h0;
  logic [31:0] prdata, rd, rd_q;
  logic pready, pslverr, idx, prox, inpos, zpf, irq, pload;
  logic [POS_W-1:0] pval;
  ahcd_pos_t pos;
  ahcd_motion_t mot;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  int msk = 0;
  int r;
  logic [31:0] lq[$];
  ahcd_homing ahcd_homing_inst (.i_clk(i_clk), .i_reset(i_reset), .i_ce(ce),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_prox_sensor(prox),
    .i_encoder_index(idx), .i_in_position_flag(inpos), .i_pos(pos), .o_motion(mot),
    .o_pos_load(pload), .o_pos_value(pval), .o_zero_pass_flag(zpf), .o_irq(irq));
  ahcd_servo_model #(.REV(REV), .DOG(DOG)) ahcd_servo_model_inst (.i_clk(i_clk),
    .i_motion(mot), .i_jog(manual_jog), .i_jog_pos(jpos), .o_pos(pos), .o_index(idx),
    .o_prox(prox), .o_inpos(inpos));
  initial forever #4 i_clk = ~i_clk;
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked = checked + 1;
    if (g !== e)
    begin
      num_errors = num_errors + 1;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Read data is captured at the completing edge, before the design's own updates land.
  always @(posedge i_clk)
  begin
    rd_q <= prdata;
    cyc <= cyc + 1;
    if (pload === 1'b1)
      cmp("pos_load", lq.size() ? lq.pop_front() : 32'hFFFFFFFF, pval);
    if (cyc == 60000)
    begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    do
      @(posedge i_clk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
    @(negedge i_clk);
    rd = rd_q;
  endtask
  task automatic rst();
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    apb(1'b1, REG_REV, 32'(REV));
    apb(1'b1, REG_IRQ_MASK, 32'h0);
  endtask
  task automatic hc(input int m, fl, jp, tr, dc, ha, ee, eh);
    int n;
    n = 0;
    @(posedge i_clk);
    manual_jog <= 1'b1;
    jpos <= 32'(jp);
    @(posedge i_clk);
    manual_jog <= 1'b0;
    apb(1'b1, REG_TRAVEL, 32'(tr));
    apb(1'b1, REG_DECEL, 32'(dc));
    apb(1'b1, REG_HOME_ADDR, 32'(ha));
    apb(1'b1, REG_CTRL, 32'((m << CTRL_METHOD_LSB) | fl | 3));
    do
    begin
      apb(1'b0, REG_IRQ_STAT, 32'h0);
      n = n + 1;
    end
    while (rd[1:0] == 2'h0 && n < 3000);
    cmp("irq_stat", ee ? 32'h2 : 32'h1, {30'h0, rd[1:0]});
    cmp("irq_out", msk ? 32'h0 : 32'h1, {31'h0, irq});
    apb(1'b0, REG_ERR_CODE, 32'h0);
    cmp("err_code", 32'(ee), {16'h0, rd[15:0]});
    if (ee == 0 && eh >= 0)
    begin
      apb(1'b0, REG_HOME_POS, 32'h0);
      cmp("home_pos", 32'(eh), rd);
    end
    apb(1'b1, REG_IRQ_STAT, 32'h7);
    cmp("irq_clear", 32'h0, {31'h0, irq});
    $display("test method %0d ended", m);
  endtask
  initial
  begin
    r = $urandom(32'heaac);
    rst();
    apb(1'b0, 8'h28, 32'h0);
    hc(AHCD_DSET2, 0, 0, 0, 0, 0, ERR_NO_ZERO, -1);
    hc(AHCD_COUNT1, 0, 0, 20, 5, 0, ERR_ZCT, -1);
    hc(AHCD_COUNT1, 8, 0, 20, 5, 0, 0, REV + 3);
    apb(1'b0, REG_STATUS, 32'h0);
    cmp("zero_pass", 32'h1, {31'h0, zpf & rd[2]});
    hc(AHCD_COUNT1, 0, 0, 60, 5, 0, 0, 2 * REV + 3);
    hc(AHCD_COUNT2, 0, 0, 60, 5, 0, 0, DOG + 60);
    hc(AHCD_COUNT2, 0, DOG + 10, 60, 5, 0, 0, DOG + 60);
    hc(AHCD_COUNT3, 0, 0, 60, 5, 0, 0, 2 * REV + 3);
    for (int m = 0; m < 3; m++)
    begin
      hc(m, 4, 0, 60, 5, 0, ERR_AMP_SENSOR, -1);
      hc(m, 0, 0, 5, 10, 0, ERR_OVERRUN, -1);
    end
    msk = 1;
    apb(1'b1, REG_IRQ_MASK, 32'h7);
    r = DOG + $urandom_range(19);
    hc(AHCD_DSET1, 16, r, 0, 0, 0, 0, r);
    msk = 0;
    apb(1'b1, REG_IRQ_MASK, 32'h0);
    hc(AHCD_DSET2, 16, r, 0, 0, 0, 0, r + 3);
    r = $urandom();
    lq.push_back(32'(r));
    hc(AHCD_DSET1, 0, DOG, 0, 0, r, 0, -1);
    rst();
    hc(AHCD_COUNT3, 0, 0, 20, 5, 0, 0, REV + 3);
    rst();
    hc(AHCD_COUNT3, 8, 0, 20, 5, 0, 0, REV + 3);
    // A write made while the enable is low must not land.
    @(posedge i_clk);
    ce <= 1'b0;
    apb(1'b1, REG_TRAVEL, 32'h5A);
    @(posedge i_clk);
    ce <= 1'b1;
    apb(1'b0, REG_TRAVEL, 32'h0);
    cmp("ce_hold", 32'h14, rd);
    cmp("loads_left", 32'h0, 32'(lq.size()));
    finish_test();
  end
endmodule
